// ===== hdl/bl_seq_pkg.sv
// Constants, register map and mode type of the backlight mode sequencer
package bl_seq_pkg;

   // Clock rates and the divider that makes the oscillator tick
   localparam int CLK_HZ              = 40_000_000;
   localparam int OSC_HZ              = 5_000_000;
   localparam int OSC_DIV             = CLK_HZ / OSC_HZ;
   localparam int OSC_DIV_W           = 3;

   // Sequencer delays in their own units, then in oscillator ticks
   localparam int STARTUP_TIME_MS     = 2;
   localparam int SOFTSTART_TIME_MS   = 4;
   localparam int IDLE_TIME_MS        = 50;
   localparam int STARTUP_TICKS       = (OSC_HZ / 1000) * STARTUP_TIME_MS;
   localparam int SOFTSTART_TICKS     = (OSC_HZ / 1000) * SOFTSTART_TIME_MS;
   localparam int IDLE_TICKS          = (OSC_HZ / 1000) * IDLE_TIME_MS;
   localparam int TIMER_W             = 15;
   localparam int IDLE_W              = 18;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_NVCFG  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_FAULT  = 8'h0c;
   localparam logic [7:0] ADDR_TEMP   = 8'h10;

   // Control register fields
   localparam int CTRL_BL_ON          = 0;
   localparam int CTRL_BOOST_EN       = 1;
   localparam logic [1:0] CTRL_RESET  = 2'h2;

   // Nonvolatile configuration fields: PLL factor and derating trip
   localparam int NV_PLL_LSB          = 0;
   localparam int NV_TRIP_LSB         = 8;
   localparam logic [15:0] NV_RESET   = 16'hc000;

   // Status register fields
   localparam int ST_MODE_LSB         = 0;
   localparam int ST_TSD              = 3;
   localparam int ST_DERATE           = 4;
   localparam int ST_PWM_ACT          = 5;
   localparam int ST_FAULT            = 6;

   localparam int LED_N               = 4;

   typedef enum logic [2:0] {
      MODE_RESET,
      MODE_STANDBY,
      MODE_STARTUP,
      MODE_BOOST_START,
      MODE_NORMAL
   } mode_e;

endpackage

// ===== hdl/backlight_mode_sequencer.sv
// Operating-mode sequencer of an LED backlight driver with Wishbone registers
//
// Functional notes
// - In reset mode every internal register but the input synchronisers and the Wishbone answer sits at its default.
// - Low regulator supply (detector active) forces reset mode.
// - Detector release lets the device leave reset for standby.
// - Standby while backlight bit low, input PWM idle, detector inactive.
// - Writes accepted in standby; control bits act right after startup.
// - Backlight bit high or PWM input high starts internal startup.
// - Startup from standby loads nonvolatile configuration and waits 2 ms.
// - Thermal shutdown stops operation and holds startup until cleared.
// - Boost soft-start follows startup only with boost-enable high.
// - Soft-start raises boost in low-current PWM for 4 ms.
// - All LED outputs stay off during the 4 ms soft-start.
// - Normal mode accepts any register write, any bits at once.
// - Temperature watched; brightness reduced at configured trip point.
// - Over-temperature turns boost and LED outputs fully off.
// - Faults shown in a status register and on the fault pin.
// - Open and short faults on the LED strings are detected.
// - One 5 MHz oscillator tick times the whole sequencer.
// - Two-bit configuration field selects the PLL multiplication.
// - PWM input counts as inactive after 50 ms low.
`timescale 1ns/1ps
module backlight_mode_sequencer
   import bl_seq_pkg::*;
#(
   parameter int STARTUP_CNT   = STARTUP_TICKS,
   parameter int SOFTSTART_CNT = SOFTSTART_TICKS,
   parameter int IDLE_CNT      = IDLE_TICKS
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Pins and analog monitors
   input  wire logic              supply_low_i,
   input  wire logic              pwm_i,
   input  wire logic              thermal_shutdown_event_i,
   input  wire logic [7:0]        temp_code_i,
   input  wire logic [LED_N-1:0]  led_open_i,
   input  wire logic [LED_N-1:0]  led_short_i,
   // Sequencer outputs
   output logic      [2:0]        mode_o,
   output logic                   core_power_o,
   output logic                   boost_on_o,
   output logic                   boost_soft_o,
   output logic      [LED_N-1:0]  led_en_o,
   output logic                   derate_o,
   output logic      [1:0]        pll_mult_o,
   output logic                   fault_o
);

   // Synchroniser stages for asynchronous inputs
   logic                  por_m, por_s;
   logic                  pwm_m, pwm_s;
   logic                  tsd_m, tsd_s;
   logic [LED_N-1:0]      open_m, open_s;
   logic [LED_N-1:0]      short_m, short_s;
   logic [7:0]            temp_m, temp_s;

   mode_e                 state;
   logic [OSC_DIV_W-1:0]  div_cnt;
   logic                  osc_tick;
   logic [TIMER_W-1:0]    timer;
   logic [IDLE_W-1:0]     idle_cnt;
   logic                  pwm_active;
   logic [1:0]            ctrl;
   logic [15:0]           nv_cfg;
   logic [15:0]           act_cfg;
   logic [LED_N-1:0]      open_flag;
   logic [LED_N-1:0]      short_flag;
   logic                  in_reset;
   logic                  wb_req;
   logic                  wb_wr;
   logic                  wake;
   logic                  derate_now;
   logic [31:0]           rd_data;

   // Timer reached the last tick of a delay
   function automatic logic delay_done(input logic [TIMER_W-1:0] cnt,
                                       input int                  limit);
      delay_done = (cnt == TIMER_W'(limit - 1));
   endfunction

   // Merge a written word into a register under byte enables
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      merge16 = old;
      if (sel[0])
      begin
         merge16[7:0] = dat[7:0];
      end
      if (sel[1])
      begin
         merge16[15:8] = dat[15:8];
      end
   endfunction

   // Two-flop synchronisers on every asynchronous input
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         por_m   <= 1'b1;
         por_s   <= 1'b1;
         pwm_m   <= 1'b0;
         pwm_s   <= 1'b0;
         tsd_m   <= 1'b0;
         tsd_s   <= 1'b0;
         open_m  <= '0;
         open_s  <= '0;
         short_m <= '0;
         short_s <= '0;
         temp_m  <= '0;
         temp_s  <= '0;
      end
      else
      begin
         por_m   <= supply_low_i;
         por_s   <= por_m;
         pwm_m   <= pwm_i;
         pwm_s   <= pwm_m;
         tsd_m   <= thermal_shutdown_event_i;
         tsd_s   <= tsd_m;
         open_m  <= led_open_i;
         open_s  <= open_m;
         short_m <= led_short_i;
         short_s <= short_m;
         temp_m  <= temp_code_i;
         temp_s  <= temp_m;
      end
   end

   // Reset mode: bus reset or supply detector active
   assign in_reset   = rst_i | por_s;
   assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr      = wb_req & wb_we_i & ~in_reset;
   assign wake       = ctrl[CTRL_BL_ON] | pwm_s;
   assign derate_now = (temp_s >= act_cfg[NV_TRIP_LSB +: 8]);

   // Oscillator tick: 5 MHz enable from the 40 MHz clock
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         div_cnt <= '0;
      end
      else if (div_cnt == OSC_DIV_W'(OSC_DIV - 1))
      begin
         div_cnt <= '0;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign osc_tick = (div_cnt == OSC_DIV_W'(OSC_DIV - 1));

   // Input PWM activity: high marks active, long low marks idle
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         idle_cnt   <= '0;
         pwm_active <= 1'b0;
      end
      else if (pwm_s)
      begin
         idle_cnt   <= '0;
         pwm_active <= 1'b1;
      end
      else if (osc_tick && pwm_active)
      begin
         if (idle_cnt == IDLE_W'(IDLE_CNT - 1))
         begin
            idle_cnt   <= '0;
            pwm_active <= 1'b0;
         end
         else
         begin
            idle_cnt <= idle_cnt + 1'b1;
         end
      end
   end

   // Mode state machine
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         state <= MODE_RESET;
         timer <= '0;
      end
      else
      begin
         case (state)
            MODE_RESET:
            begin
               state <= MODE_STANDBY;
               timer <= '0;
            end
            MODE_STANDBY:
            begin
               timer <= '0;
               if (wake)
               begin
                  state <= MODE_STARTUP;
               end
            end
            MODE_STARTUP:
            begin
               if (tsd_s)
               begin
                  timer <= '0;
               end
               else if (osc_tick)
               begin
                  if (delay_done(timer, STARTUP_CNT))
                  begin
                     timer <= '0;
                     if (!(wake | pwm_active))
                     begin
                        state <= MODE_STANDBY;
                     end
                     else if (ctrl[CTRL_BOOST_EN])
                     begin
                        state <= MODE_BOOST_START;
                     end
                     else
                     begin
                        state <= MODE_NORMAL;
                     end
                  end
                  else
                  begin
                     timer <= timer + 1'b1;
                  end
               end
            end
            MODE_BOOST_START:
            begin
               if (tsd_s)
               begin
                  state <= MODE_STARTUP;
                  timer <= '0;
               end
               else if (osc_tick)
               begin
                  if (delay_done(timer, SOFTSTART_CNT))
                  begin
                     timer <= '0;
                     state <= MODE_NORMAL;
                  end
                  else
                  begin
                     timer <= timer + 1'b1;
                  end
               end
            end
            MODE_NORMAL:
            begin
               timer <= '0;
               if (tsd_s)
               begin
                  state <= MODE_STARTUP;
               end
               else if (!(ctrl[CTRL_BL_ON] | pwm_active))
               begin
                  state <= MODE_STANDBY;
               end
            end
            default:
            begin
               state <= MODE_RESET;
               timer <= '0;
            end
         endcase
      end
   end

   // Control register: writable in every mode but reset
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         ctrl <= CTRL_RESET;
      end
      else if (wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0])
      begin
         ctrl <= wb_dat_i[1:0];
      end
   end

   // Nonvolatile configuration image, written by software
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         nv_cfg <= NV_RESET;
      end
      else if (wb_wr && wb_adr_i == ADDR_NVCFG)
      begin
         nv_cfg <= merge16(nv_cfg, wb_dat_i, wb_sel_i);
      end
   end

   // Active configuration, loaded from the image on startup entry from standby
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         act_cfg <= NV_RESET;
      end
      else if (state == MODE_STANDBY && wake)
      begin
         act_cfg <= nv_cfg;
      end
   end

   // Sticky LED string faults; detection wins over a clear
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         open_flag  <= '0;
         short_flag <= '0;
      end
      else
      begin
         if (wb_wr && wb_adr_i == ADDR_FAULT && wb_sel_i[0])
         begin
            open_flag  <= (open_flag & ~wb_dat_i[3:0]) | open_s;
            short_flag <= (short_flag & ~wb_dat_i[7:4]) | short_s;
         end
         else
         begin
            open_flag  <= open_flag | open_s;
            short_flag <= short_flag | short_s;
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rd_data = '0;
      case (wb_adr_i)
         ADDR_CTRL:   rd_data[1:0]  = ctrl;
         ADDR_NVCFG:  rd_data[15:0] = nv_cfg;
         ADDR_STATUS:
         begin
            rd_data[ST_MODE_LSB +: 3] = state;
            rd_data[ST_TSD]           = tsd_s;
            rd_data[ST_DERATE]        = derate_now;
            rd_data[ST_PWM_ACT]       = pwm_active;
            rd_data[ST_FAULT]         = |{open_flag, short_flag, tsd_s};
         end
         ADDR_FAULT:  rd_data[7:0]  = {short_flag, open_flag};
         ADDR_TEMP:   rd_data[7:0]  = temp_s;
         default:     rd_data       = '0;
      endcase
   end

   // Wishbone answer: ack one cycle after the request
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
      end
   end

   // Registered sequencer outputs
   always_ff @(posedge clk_i)
   begin
      if (in_reset)
      begin
         mode_o       <= MODE_RESET;
         core_power_o <= 1'b0;
         boost_on_o   <= 1'b0;
         boost_soft_o <= 1'b0;
         led_en_o     <= '0;
         derate_o     <= 1'b0;
         pll_mult_o   <= NV_RESET[NV_PLL_LSB +: 2];
         fault_o      <= 1'b0;
      end
      else
      begin
         mode_o       <= state;
         core_power_o <= (state != MODE_STANDBY) && (state != MODE_RESET);
         boost_on_o   <= !tsd_s && ((state == MODE_BOOST_START)
                         || (state == MODE_NORMAL));
         boost_soft_o <= !tsd_s && (state == MODE_BOOST_START);
         led_en_o     <= (!tsd_s && state == MODE_NORMAL) ?
                         ~(open_flag | short_flag) : '0;
         derate_o     <= derate_now;
         pll_mult_o   <= act_cfg[NV_PLL_LSB +: 2];
         fault_o      <= |{open_flag, short_flag, tsd_s};
      end
   end

endmodule

// ===== test/bl_seq_asserts.sv
// Port checker of the backlight mode sequencer and its bind
`timescale 1ns/1ps
module bl_seq_chk
   import bl_seq_pkg::*;
#(
   parameter int STARTUP_CNT   = STARTUP_TICKS,
   parameter int SOFTSTART_CNT = SOFTSTART_TICKS,
   parameter int IDLE_CNT      = IDLE_TICKS
)
(
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_ack_o,
   input wire logic             supply_low_i,
   input wire logic             pwm_i,
   input wire logic             thermal_shutdown_event_i,
   input wire logic [LED_N-1:0] led_open_i,
   input wire logic [LED_N-1:0] led_short_i,
   input wire logic [2:0]       mode_o,
   input wire logic             core_power_o,
   input wire logic             boost_on_o,
   input wire logic             boost_soft_o,
   input wire logic [LED_N-1:0] led_en_o,
   input wire logic [1:0]       pll_mult_o,
   input wire logic             fault_o
);
   localparam int ST_LO = STARTUP_CNT * OSC_DIV - 10;
   localparam int ST_HI = STARTUP_CNT * OSC_DIV + 16;
   localparam int SS_LO = SOFTSTART_CNT * OSC_DIV - 10;
   localparam int SS_HI = SOFTSTART_CNT * OSC_DIV + 16;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [19:0] st_n;
   logic [19:0] bs_n;
   // Length of the startup phase, restarted by a thermal event
   always_ff @(posedge clk_i)
      if (rst_i || mode_o != 3'h2 || thermal_shutdown_event_i)
         st_n <= 20'h0;
      else
         st_n <= st_n + 20'h1;
   // Length of the soft-start regime
   always_ff @(posedge clk_i)
      if (rst_i || !boost_soft_o)
         bs_n <= 20'h0;
      else
         bs_n <= bs_n + 20'h1;
   // Building blocks
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_low;
      supply_low_i [*5];
   endsequence
   sequence s_hot;
      thermal_shutdown_event_i [*4];
   endsequence
   property p_ack;
      s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   property p_por_mode;
      s_low |=> mode_o == 3'h0;
   endproperty
   property p_por_regs;
      s_low |=> !core_power_o && !boost_on_o && led_en_o == '0 && pll_mult_o == 2'h0;
   endproperty
   property p_wake;
      mode_o == 3'h1 && pwm_i ##1 pwm_i [*5] |=> core_power_o;
   endproperty
   property p_st_len;
      $past(mode_o) == 3'h2 && (mode_o == 3'h3 || mode_o == 3'h4) |-> st_n >= ST_LO && st_n <= ST_HI;
   endproperty
   property p_tsd_mode;
      s_hot ##1 thermal_shutdown_event_i [*2] |-> mode_o inside {3'h0, 3'h1, 3'h2};
   endproperty
   property p_soft_len;
      $fell(boost_soft_o) && !thermal_shutdown_event_i |-> bs_n >= SS_LO && bs_n <= SS_HI;
   endproperty
   property p_soft_dark;
      boost_soft_o |-> led_en_o == '0;
   endproperty
   property p_tsd_off;
      s_hot |-> !boost_on_o && led_en_o == '0;
   endproperty
   property p_fault;
      ((|led_open_i || |led_short_i) && !supply_low_i) [*6] |=> fault_o;
   endproperty
   property p_boost_exit;
      $past(mode_o) == 3'h3 && mode_o != 3'h3 |-> mode_o inside {3'h0, 3'h2, 3'h4};
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_por_mode: assert property (p_por_mode) else $error("mode not reset");
   a_por_regs: assert property (p_por_regs) else $error("outputs not default");
   a_wake: assert property (p_wake) else $error("no wake on pwm");
   a_st_len: assert property (p_st_len) else $error("startup length");
   a_tsd_mode: assert property (p_tsd_mode) else $error("mode under thermal");
   a_soft_len: assert property (p_soft_len) else $error("soft-start length");
   a_soft_dark: assert property (p_soft_dark) else $error("led on in soft-start");
   a_tsd_off: assert property (p_tsd_off) else $error("power under thermal");
   a_fault: assert property (p_fault) else $error("fault pin low");
   a_boost_exit: assert property (p_boost_exit) else $error("bad soft-start exit");
endmodule

bind backlight_mode_sequencer bl_seq_chk #(
   .STARTUP_CNT(STARTUP_CNT), .SOFTSTART_CNT(SOFTSTART_CNT), .IDLE_CNT(IDLE_CNT)
) i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .supply_low_i(supply_low_i), .pwm_i(pwm_i),
   .thermal_shutdown_event_i(thermal_shutdown_event_i), .led_open_i(led_open_i),
   .led_short_i(led_short_i), .mode_o(mode_o), .core_power_o(core_power_o),
   .boost_on_o(boost_on_o), .boost_soft_o(boost_soft_o), .led_en_o(led_en_o),
   .pll_mult_o(pll_mult_o), .fault_o(fault_o)
);

// ===== test/bl_host_model.sv
// Host processor model: classic Wishbone master
`timescale 1ns/1ps
module bl_host_model
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   int unsigned gap = 0; // Idle cycles before each request
   // Idle bus at time zero
   initial
   begin
      {cyc_o, stb_o, we_o} = 3'h0;
      {adr_o, sel_o, dat_o} = '0;
   end
   // One cycle, held until ack is sampled; released address, select and data show inverted values
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o} <= {2'h3, w};
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      {cyc_o, stb_o, we_o} <= 3'h0;
      adr_o <= ~a;
      sel_o <= ~s;
      dat_o <= ~d;
   endtask
endmodule

// ===== test/backlight_mode_sequencer_tb.sv
// Self-checking bench of the backlight mode sequencer
`timescale 1ns/1ps
module backlight_mode_sequencer_tb;
   import bl_seq_pkg::*;
   localparam int SC = 4;
   localparam int FC = 8;
   localparam int IC = 16;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, core, bon, bsoft, derate, fault;
   logic        supply_low = 1'b0, pwm = 1'b0, thermal_shutdown_event = 1'b0;
   logic [7:0]  adr;
   logic [7:0]  temp = 8'h0;
   logic [3:0]  sel, led;
   logic [3:0]  lopen = 4'h0, lshort = 4'h0;
   logic [31:0] wdat, rdat, rnd;
   logic [2:0]  mode;
   logic [1:0]  pll;
   logic [63:0] exp_q[$];
   int          errors = 0;
   int          samples_checked = 0;

   always #12.5 clk_i = ~clk_i;

   bl_host_model i_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   backlight_mode_sequencer #(.STARTUP_CNT(SC), .SOFTSTART_CNT(FC), .IDLE_CNT(IC)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .supply_low_i(supply_low), .pwm_i(pwm), .thermal_shutdown_event_i(thermal_shutdown_event),
      .temp_code_i(temp), .led_open_i(lopen), .led_short_i(lshort), .mode_o(mode),
      .core_power_o(core), .boost_on_o(bon), .boost_soft_o(bsoft), .led_en_o(led),
      .derate_o(derate), .pll_mult_o(pll), .fault_o(fault));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      i_host.bus(1'b1, a, d, s);
   endtask
   // Note the masked expectation, then read
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({m, e & m});
      i_host.bus(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Each read answer against the oldest note
   always @(posedge clk_i)
      if (ack === 1'b1 && we === 1'b0)
      begin
         logic [63:0] n;
         n = exp_q.pop_front();
         chk("read", n[31:0], rdat & n[63:32]);
      end

   // Watchdog
   initial
   begin
      step(20000);
      errors++;
      $display("[ERR] run expected finish seen timeout");
      final_report();
   end

   initial
   begin
      void'($urandom(96));
      step(12);
      rst_i <= 1'b0;
      step(4);
      rd(ADDR_CTRL, 32'h2, 32'h3);
      rd(ADDR_NVCFG, 32'hc000, 32'hff03);
      rd(ADDR_STATUS, 32'h1, 32'h7f);
      rd(8'h14, 32'h0, 32'hffffffff);
      chk("core_power", 32'h0, {31'h0, core});
      $display("defaults done");
      rnd = $urandom | 32'h100;
      i_host.gap = int'(rnd[17:16]);
      wr(ADDR_NVCFG, rnd, 4'h3);
      rd(ADDR_NVCFG, rnd, 32'hff03);
      wr(ADDR_CTRL, 32'h3, 4'h1);
      rd(ADDR_STATUS, 32'h2, 32'h7);
      chk("pll", {30'h0, rnd[1:0]}, {30'h0, pll});
      chk("core_power", 32'h1, {31'h0, core});
      step(8 * SC + 8);
      rd(ADDR_STATUS, 32'h3, 32'h7);
      chk("soft", 32'h1, {31'h0, bsoft});
      chk("led_en", 32'h0, {28'h0, led});
      step(8 * FC + 8);
      rd(ADDR_STATUS, 32'h4, 32'h7);
      chk("led_en", 32'hf, {28'h0, led});
      $display("startup done");
      temp <= rnd[15:8];
      step(6);
      chk("derate", 32'h1, {31'h0, derate});
      rd(ADDR_TEMP, {24'h0, rnd[15:8]}, 32'hff);
      temp <= rnd[15:8] - 8'h1;
      step(6);
      chk("derate", 32'h0, {31'h0, derate});
      $display("derating done");
      thermal_shutdown_event <= 1'b1;
      step(5);
      chk("boost_on", 32'h0, {31'h0, bon});
      chk("led_en", 32'h0, {28'h0, led});
      step(8 * SC + 8);
      rd(ADDR_STATUS, 32'ha, 32'hf);
      thermal_shutdown_event <= 1'b0;
      step(8 * SC + 8 * FC + 24);
      rd(ADDR_STATUS, 32'h4, 32'hf);
      $display("thermal done");
      lopen <= 4'h1;
      lshort <= 4'h4;
      step(6);
      chk("fault_pin", 32'h1, {31'h0, fault});
      chk("led_en", 32'ha, {28'h0, led});
      rd(ADDR_FAULT, 32'h41, 32'hff);
      lopen <= 4'h0;
      lshort <= 4'h0;
      step(4);
      wr(ADDR_FAULT, 32'h41, 4'h1);
      rd(ADDR_FAULT, 32'h0, 32'hff);
      chk("fault_pin", 32'h0, {31'h0, fault});
      $display("faults done");
      pwm <= 1'b1;
      step(4);
      wr(ADDR_CTRL, 32'h0, 4'h1);
      rd(ADDR_STATUS, 32'h24, 32'h27);
      pwm <= 1'b0;
      step(8 * IC - 16);
      rd(ADDR_STATUS, 32'h4, 32'h7);
      step(40);
      rd(ADDR_STATUS, 32'h1, 32'h27);
      pwm <= 1'b1;
      step(8 * SC + 12);
      rd(ADDR_STATUS, 32'h24, 32'h27);
      chk("soft", 32'h0, {31'h0, bsoft});
      $display("pwm control done");
      supply_low <= 1'b1;
      pwm <= 1'b0;
      step(6);
      chk("mode", 32'h0, {29'h0, mode});
      chk("pll", 32'h0, {30'h0, pll});
      wr(ADDR_CTRL, 32'h1, 4'h1);
      rd(ADDR_CTRL, 32'h2, 32'h3);
      supply_low <= 1'b0;
      step(6);
      rd(ADDR_STATUS, 32'h1, 32'h7);
      $display("supply done");
      final_report();
   end
endmodule
